// file: core_seq.sv
// fetch/execute sequencer with alu flag register and wishbone view
//
// Function
// - four phases per instruction cycle
// - fetch next while executing current
// - pointer change flushes, costs two cycles
// - pointer increments in phase one
// - latch word phase one, execute after
// - operand read phase two, write phase four
// - program memory byte addressed, even aligned
// - pointer steps by two, bit zero zero
// - jump/call load word address bits 12:1, bits 20:13 cleared
// - relative branch offset counted in words
// - flag register writable as any destination
// - flag writes suppressed when alu sets flags
// - clear on flags leaves 000u u1uu
// - negative copies result msb
// - digit carry from bit 3; rotates
// - carry out of msb for add/sub
// - rotate through carry loads shifted bit
// - subtract adds two's complement, inverted borrow
`timescale 1ns/100ps
module core_seq
    import core_seq_pkg::*;
#(
    parameter int DADDR_W = 8 // data memory address width
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // synchronous reset, high
    output logic [PC_W-1:0] pmem_addr_o, // program byte address
    output logic pmem_rd_o, // program read strobe
    input wire logic [15:0] pmem_data_i, // instruction word
    output logic [DADDR_W-1:0] dmem_addr_o, // data address
    output logic dmem_rd_o, // operand read strobe
    input wire logic [7:0] dmem_rdata_i, // operand data
    output logic dmem_we_o, // destination write strobe
    output logic [7:0] dmem_wdata_o, // destination data
    output logic [7:0] accum_o, // working register
    output logic [1:0] phase_o, // current phase
    input wire logic [31:0] wb_adr_i, // wishbone address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    input wire logic wb_we_i, // wishbone write
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o // acknowledge
);
    initial begin
        // the file address field of the word is eight bits wide
        if (DADDR_W < 1 || DADDR_W > 8) begin
            $error("core_seq: DADDR_W out of range");
        end
    end

    localparam logic [DADDR_W-1:0] FLAGS_DADDR = {DADDR_W{1'b1}};

    typedef struct packed {
        phase_t ph;
        logic [PC_W-1:0] pc;
        logic [15:0] fetch;
        logic [15:0] ir;
        logic ir_valid;
        logic fetch_valid;
        logic flush;
        logic [7:0] opnd;
        logic [7:0] res;
        logic [7:0] wreg;
        logic [4:0] flags;
        logic [4:0] newf;
        logic setf;
        logic wr;
        logic run;
        logic ack;
        logic [31:0] rdat;
    } state_t;

    state_t s_q, s_d;

    // decoded fields of the executing word
    logic [3:0] op;
    logic [7:0] fld;
    logic tgt_flags;
    logic wb_req;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b;
    logic cin;
    logic [PC_W-1:0] br_off;

    assign op = s_q.ir[15:12];
    assign fld = s_q.ir[7:0];
    // flag register reached by the select bit or by the all-ones file address
    assign tgt_flags = (fld[DADDR_W-1:0] == FLAGS_DADDR) | s_q.ir[11];
    assign wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign br_off = {{(PC_W-9){fld[7]}}, fld, 1'b0}; // word offset to bytes

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        s_d.ack = wb_req;
        b = 8'h00;
        cin = 1'b0;
        sum = 9'h000;
        nib = 5'h00;
        case (s_q.ph)
            PH_ONE: begin
                s_d.ph = PH_TWO;
                if (s_q.run) begin
                    s_d.ir = s_q.fetch;
                    s_d.ir_valid = s_q.fetch_valid & ~s_q.flush; // discarded slot
                    s_d.flush = 1'b0;
                    // no step right after a pointer load, so the target word itself is fetched next
                    if (s_q.fetch_valid && !s_q.flush) begin
                        s_d.pc = s_q.pc + PC_STEP;
                    end
                end else begin
                    s_d.ir_valid = 1'b0; // a stopped core must not replay the last word
                end
            end
            PH_TWO: begin
                s_d.ph = PH_THREE;
                s_d.opnd = tgt_flags ? {3'b000, s_q.flags} : dmem_rdata_i;
            end
            PH_THREE: begin
                s_d.ph = PH_FOUR;
                s_d.setf = 1'b0;
                s_d.wr = 1'b0;
                s_d.newf = s_q.flags;
                s_d.res = s_q.opnd;
                if (s_q.ir_valid) begin
                    b = s_q.wreg;
                    cin = 1'b0;
                    if (op == OP_SUB) begin
                        b = ~s_q.wreg;
                        cin = 1'b1;
                    end
                    sum = {1'b0, s_q.opnd} + {1'b0, b} + {8'h00, cin};
                    nib = {1'b0, s_q.opnd[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                    case (op)
                        OP_ADD, OP_SUB: begin
                            s_d.res = sum[7:0];
                            s_d.setf = 1'b1;
                            s_d.newf[FLAG_C] = sum[8];
                            s_d.newf[FLAG_DC] = nib[4];
                            s_d.newf[FLAG_OV] = (s_q.opnd[7] == b[7]) & (sum[7] != s_q.opnd[7]);
                        end
                        OP_AND: s_d.res = s_q.opnd & s_q.wreg;
                        OP_IOR: s_d.res = s_q.opnd | s_q.wreg;
                        OP_XOR: s_d.res = s_q.opnd ^ s_q.wreg;
                        OP_CLR: s_d.res = 8'h00;
                        OP_RRC: begin
                            s_d.res = {s_q.flags[FLAG_C], s_q.opnd[7:1]};
                            s_d.newf[FLAG_C] = s_q.opnd[0];
                            s_d.newf[FLAG_DC] = s_q.opnd[4];
                        end
                        OP_RLC: begin
                            s_d.res = {s_q.opnd[6:0], s_q.flags[FLAG_C]};
                            s_d.newf[FLAG_C] = s_q.opnd[7];
                            s_d.newf[FLAG_DC] = s_q.opnd[3];
                        end
                        OP_MOV: s_d.res = s_q.wreg;
                        OP_SWAP: s_d.res = {s_q.opnd[3:0], s_q.opnd[7:4]};
                        OP_BCLR: s_d.res = s_q.opnd & ~(8'h01 << s_q.ir[10:8]);
                        OP_BSET: s_d.res = s_q.opnd | (8'h01 << s_q.ir[10:8]);
                        default: s_d.res = s_q.opnd;
                    endcase
                    // logic and rotate ops also drive n and z; clear drives z alone
                    if (op == OP_ADD || op == OP_SUB || op == OP_AND || op == OP_IOR || op == OP_XOR ||
                        op == OP_CLR || op == OP_RRC || op == OP_RLC) begin
                        s_d.setf = 1'b1;
                        if (op != OP_CLR) begin
                            s_d.newf[FLAG_N] = s_d.res[7];
                        end
                        s_d.newf[FLAG_Z] = (s_d.res == 8'h00);
                    end
                    s_d.wr = (op != OP_NOP) && (op < OP_JMP);
                end
            end
            PH_FOUR: begin
                s_d.ph = PH_ONE;
                if (s_q.wr && tgt_flags) begin
                    // alu flags win over the stored value
                    s_d.flags = s_q.setf ? s_q.newf : s_q.res[4:0];
                end else begin
                    s_d.flags = s_q.newf;
                end
                if (s_q.ir_valid && s_q.ir[11] == 1'b0 && s_q.wr && !tgt_flags && op == OP_MOV) begin
                    s_d.wreg = s_q.wreg;
                end
                if (s_q.ir_valid && (op == OP_JMP || op == OP_CALL)) begin
                    s_d.pc = {8'h00, s_q.ir[11:0], 1'b0}; // word address to bits 12:1, bits 20:13 cleared
                    s_d.flush = 1'b1;
                end else if (s_q.ir_valid && op == OP_BRA) begin
                    s_d.pc = s_q.pc + br_off;
                    s_d.flush = 1'b1;
                end
                // next word fetched while this one executes
                s_d.fetch = pmem_data_i;
                s_d.fetch_valid = s_q.run;
            end
            default: s_d.ph = PH_ONE;
        endcase
        s_d.pc[0] = 1'b0;
        ////////////////////////////////////////////////////////////////////
        // wishbone writes: accumulator and run control
        if (wb_req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i[7:0])
                ADDR_CTRL: s_d.run = wb_dat_i[0];
                ADDR_PTR: s_d.wreg = wb_dat_i[7:0];
                default: s_d.run = s_d.run;
            endcase
        end
        // wishbone reads, unmapped reads zero
        case (wb_adr_i[7:0])
            ADDR_FLAGS: s_d.rdat = {24'h00_0000, 3'b000, s_q.flags};
            ADDR_PTR: s_d.rdat = {11'h000, s_q.pc};
            ADDR_LATCH: s_d.rdat = {16'h0000, s_q.ir};
            ADDR_CTRL: s_d.rdat = {23'h00_0000, s_q.wreg, s_q.run};
            default: s_d.rdat = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; flags reset to a fixed value although software must not rely on it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.pc <= PC_RESET;
            s_q.flags <= FLAGS_RESET[4:0];
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign pmem_addr_o = s_q.pc;
    assign pmem_rd_o = s_q.run && (s_q.ph == PH_FOUR);
    assign dmem_addr_o = fld[DADDR_W-1:0];
    assign dmem_rd_o = s_q.ir_valid && (s_q.ph == PH_TWO) && !tgt_flags;
    assign dmem_we_o = s_q.wr && (s_q.ph == PH_FOUR) && !tgt_flags;
    assign dmem_wdata_o = s_q.res;
    assign accum_o = s_q.wreg;
    assign phase_o = s_q.ph;
    assign wb_dat_o = s_q.ack ? s_q.rdat : 32'h0000_0000;
    assign wb_ack_o = s_q.ack;
endmodule // core_seq

// file: core_seq_pkg.sv
// constants and types for the core sequencer
package core_seq_pkg;
    localparam int PC_W = 21;
    localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;
    // flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam logic [7:0] FLAG_MASK = 8'h1F;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_PTR = 8'h04;
    localparam logic [7:0] ADDR_LATCH = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    // alu operation codes carried in the latched word, bits 15:12
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_ADD = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_AND = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_XOR = 4'h5;
    localparam logic [3:0] OP_CLR = 4'h6;
    localparam logic [3:0] OP_RRC = 4'h7;
    localparam logic [3:0] OP_RLC = 4'h8;
    localparam logic [3:0] OP_MOV = 4'h9;
    localparam logic [3:0] OP_SWAP = 4'hA;
    localparam logic [3:0] OP_BCLR = 4'hB;
    localparam logic [3:0] OP_BSET = 4'hC;
    localparam logic [3:0] OP_JMP = 4'hD;
    localparam logic [3:0] OP_BRA = 4'hE;
    localparam logic [3:0] OP_CALL = 4'hF;
    // phases of one instruction cycle, gray coded
    typedef enum logic [1:0] {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b11,
        PH_FOUR = 2'b10
    } phase_t;
endpackage

// file: core_seq_checker.sv
// concurrent checks on the core sequencer ports
`timescale 1ns/100ps
module core_seq_checker
    import core_seq_pkg::*;
#(
    parameter int DADDR_W = 8 // data address width
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic [PC_W-1:0] pmem_addr_o, // program address
    input wire logic pmem_rd_o, // fetch strobe
    input wire logic [DADDR_W-1:0] dmem_addr_o, // data address
    input wire logic dmem_rd_o, // operand read
    input wire logic dmem_we_o, // destination write
    input wire logic [1:0] phase_o, // phase
    input wire logic [31:0] wb_adr_i, // bus address
    input wire logic [31:0] wb_dat_o, // bus read data
    input wire logic wb_we_i, // bus write
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_ack_o // bus ack
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // phases walk one, two, three, four and wrap
    phase_walk_a: assert property (phase_o == 2'b00 |=> phase_o == 2'b01 ##1 phase_o == 2'b11
        ##1 phase_o == 2'b10 ##1 phase_o == 2'b00) else $error("phase order broken");
    ptr_even_a: assert property (pmem_addr_o[0] == 1'b0) else $error("odd pointer");
    // steps of two come out of phase one only; loads of a target come out of phase four
    ptr_step_a: assert property ($changed(pmem_addr_o) |->
        ($past(phase_o) == 2'b00 && pmem_addr_o == $past(pmem_addr_o) + PC_STEP) || $past(phase_o) == 2'b10)
        else $error("bad step");
    rd_phase_a: assert property (dmem_rd_o |-> phase_o == 2'b01) else $error("read off phase two");
    we_phase_a: assert property (dmem_we_o |-> phase_o == 2'b10) else $error("write off phase four");
    fetch_phase_a: assert property (pmem_rd_o |-> phase_o == 2'b10) else $error("fetch off phase");
    flag_guard_a: assert property (dmem_we_o |-> dmem_addr_o != {DADDR_W{1'b1}})
        else $error("flag file written");
    flag_upper_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:0] == ADDR_FLAGS
        |-> wb_dat_o[7:5] == 3'b000) else $error("upper flag bits set");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing");
    cover property (dmem_we_o);
    cover property (pmem_rd_o && pmem_addr_o != '0);
    cover property (wb_ack_o && wb_we_i);
endmodule // core_seq_checker

bind core_seq core_seq_checker #(.DADDR_W(DADDR_W)) core_seq_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o), .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o),
    .dmem_we_o(dmem_we_o), .phase_o(phase_o), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// file: core_seq_mem.sv
// program and data memory model facing the core sequencer
`timescale 1ns/100ps
module core_seq_mem (
    input wire logic clk_i, // core clock
    input wire logic [20:0] pmem_addr_i, // program byte address
    input wire logic pmem_rd_i, // fetch strobe
    output logic [15:0] pmem_data_o, // instruction word
    input wire logic [7:0] dmem_addr_i, // data address
    input wire logic dmem_rd_i, // read strobe
    input wire logic dmem_we_i, // write strobe
    input wire logic [7:0] dmem_wdata_i, // write data
    output logic [7:0] dmem_rdata_o // read data
);
    logic [15:0] prog [256];
    logic [7:0] dram [256];
    // byte address drops bit zero; off strobe the lines show inverted data, never a stale match
    assign pmem_data_o = pmem_rd_i ? prog[pmem_addr_i[8:1]] : ~prog[pmem_addr_i[8:1]];
    assign dmem_rdata_o = dmem_rd_i ? dram[dmem_addr_i] : ~dram[dmem_addr_i];
    // plain always so the bench may preload the array
    always @(posedge clk_i) begin
        if (dmem_we_i) begin
            dram[dmem_addr_i] <= dmem_wdata_i;
        end
    end
endmodule // core_seq_mem

// file: core_seq_tb.sv
// self-checking bench for the core sequencer
`timescale 1ns/100ps
module core_seq_tb;
    import core_seq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [PC_W-1:0] pmem_addr_o;
    logic pmem_rd_o, dmem_rd_o, dmem_we_o, wb_ack_o;
    logic [15:0] pmem_data_i;
    logic [7:0] dmem_addr_o, dmem_rdata_i, dmem_wdata_o, accum_o;
    logic [1:0] phase_o;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, q;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    int errors = 0;
    int checks = 0;
    core_seq core_seq_i (.clk_i(clk_i), .rst_i(rst_i), .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
        .pmem_data_i(pmem_data_i), .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o), .dmem_rdata_i(dmem_rdata_i),
        .dmem_we_o(dmem_we_o), .dmem_wdata_o(dmem_wdata_o), .accum_o(accum_o), .phase_o(phase_o), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'h1), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
    core_seq_mem core_seq_mem_i (.clk_i(clk_i), .pmem_addr_i(pmem_addr_o), .pmem_rd_i(pmem_rd_o),
        .pmem_data_o(pmem_data_i), .dmem_addr_i(dmem_addr_o), .dmem_rd_i(dmem_rd_o), .dmem_we_i(dmem_we_o),
        .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic finish_test();
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks++;
        if ((got & m) !== (exp & m)) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one classic cycle; held until ack is sampled, then a free cycle
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        wb_adr_i <= {24'h00_0000, a};
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        chk(n, 2, 32'hFFFF_FFFF); // ack one cycle after the request is taken; a timeout fails here too
    endtask
    // restart, load two words, run ten instruction cycles, read flags and the file back
    task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [7:0] acc, input logic [7:0] fv,
                       input logic [7:0] rv, input logic [7:0] exp, input logic [7:0] m);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        core_seq_mem_i.prog[0] = w0;
        core_seq_mem_i.prog[1] = w1;
        core_seq_mem_i.dram[8'h10] = fv;
        bus(ADDR_PTR, 1'b1, {24'h00_0000, acc});
        chk({24'h00_0000, accum_o}, {24'h00_0000, acc}, 32'h0000_00FF);
        bus(ADDR_CTRL, 1'b1, 32'h0000_0001);
        repeat (40) @(posedge clk_i);
        bus(ADDR_CTRL, 1'b1, 32'h0000_0000);
        bus(ADDR_FLAGS, 1'b0, 32'h0000_0000);
        chk(q, {24'h00_0000, exp}, {24'h00_0000, m});
        chk({24'h00_0000, core_seq_mem_i.dram[8'h10]}, {24'h00_0000, rv}, 32'h0000_00FF);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++) begin
            core_seq_mem_i.prog[i] = 16'h0000;
            core_seq_mem_i.dram[i] = 8'h00;
        end
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // the flag register is read only from the bus side
        bus(ADDR_FLAGS, 1'b1, 32'h0000_00FF);
        bus(ADDR_FLAGS, 1'b0, 32'h0000_0000);
        chk(q, {24'h00_0000, FLAGS_RESET}, 32'hFFFF_FFFF);
        bus(8'h10, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_0000, 32'hFFFF_FFFF);
        run(16'h1010, 16'h0000, 8'h80, 8'h80, 8'h00, 8'h0D, 8'h1F);
        run(16'h1010, 16'h0000, 8'h48, 8'h48, 8'h90, 8'h1A, 8'h1F);
        run(16'h2010, 16'h0000, 8'h55, 8'h55, 8'h00, 8'h07, 8'h1F);
        // flags preset by a flagless move, then cleared as a destination
        run(16'h9800, 16'h6800, 8'h1B, 8'h33, 8'h33, 8'h1F, 8'hFF);
        run(16'h1800, 16'h0000, 8'hFF, 8'h44, 8'h44, 8'h10, 8'hFF);
        run(16'h7010, 16'h0000, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01);
        run(16'h8010, 16'h0000, 8'h00, 8'h80, 8'h00, 8'h01, 8'h01);
        run(16'hD000, 16'h1010, 8'h80, 8'h80, 8'h80, 8'h00, 8'h1F);
        finish_test();
    end
    // watchdog well past the eight program runs
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        finish_test();
    end
endmodule // core_seq_tb
